// ---- verilog/audio_port_regs.svh ----
// Constants shared by the audio serial port ends: control word fields, clocks and offsets.
// Contract
// - Timing derives from nominal 12.288 MHz master clock; the code divides the 40 MHz system clock instead.
// - Rate 48, 96, 192 kHz from pins or word.
// - Clock source never exceeds the nominal master rate.
// - Configuration by serial control word or pins.
// - Control word 16 bits; bits 15:10 ignored.
// - Audio link uses frame, bit, data signals only.
// - Frame clock marks channels at the sample rate.
// - Bit clock 64 times rate, 32 per slot.
// - Serial data changes on bit clock falling edge.
// - Format standard, left or right justified selectable.
// - Sample width 16, 20 or 24 bits.
// - Standard: MSB first, second period after change.
// - Standard: falling frame edge starts left sample.
// - Left-justified: MSB first, first period after change.
// - Right-justified: LSB in last slot period.
// - Justified modes: rising frame edge starts left.
// - Format code 00 std, 01 left, 10 right.
// - Rate code 00 48k, 01 96k, 10 192k.
// - Width code 00 24, 01 20, 10 16.
// - Word layout width, mutes, master, format, rate, filter.
`ifndef AUDIO_PORT_REGS_SVH
`define AUDIO_PORT_REGS_SVH

// System clock and the nominal converter clocks in hertz.
`define SYS_CLK_HZ     40000000
`define MCLK_HZ        12288000
`define MOD_HZ         6144000
`define FS_48K_HZ      48000
`define FS_96K_HZ      96000
`define FS_192K_HZ     192000
`define BCLK_PER_FS    64

// Bit clock half period in system cycles, rounded up so the link never runs fast.
`define HALF_CYC(fs) ((`SYS_CLK_HZ + 2 * `BCLK_PER_FS * (fs) - 1) / (2 * `BCLK_PER_FS * (fs)))

// Control word layout.
`define CW_WIDTH       16
`define CW_RESET       16'h0000
`define CW_WW_HI       9
`define CW_WW_LO       8
`define CW_MUTE_R      7
`define CW_MUTE_L      6
`define CW_MASTER      5
`define CW_FMT_HI      4
`define CW_FMT_LO      3
`define CW_RATE_HI     2
`define CW_RATE_LO     1
`define CW_HPE         0
`define CW_COUNT       5'h10

// Frame geometry.
`define SLOT_LAST      5'h1f
`define SLOT_SIZE      6'h20
`define FRAME_LAST     6'h3f
`define SAMPLE_MSB     6'h17
`define BITS_24        6'h18
`define BITS_20        6'h14
`define BITS_16        6'h10

// Controller register map and status bits.
`define REG_CTRL       8'h00
`define REG_STATUS     8'h04
`define REG_LEFT       8'h08
`define REG_RIGHT      8'h0c
`define ST_BUSY        0
`define ST_READY       1
`define SPI_HALF_CYC   4'h4

`endif

// ---- verilog/audio_port_pkg.sv ----
// Types shared by the audio serial port ends.
package audio_port_pkg;
  // Output format codes.
  typedef enum logic [1:0] {FMT_STD = 2'b00, FMT_LJ = 2'b01, FMT_RJ = 2'b10,
                            FMT_RSV = 2'b11} fmt_e;
  // Sample rate codes.
  typedef enum logic [1:0] {RATE_48K = 2'b00, RATE_96K = 2'b01, RATE_192K = 2'b10,
                            RATE_RSV = 2'b11} rate_e;
  // Word width codes.
  typedef enum logic [1:0] {WID_24 = 2'b00, WID_20 = 2'b01, WID_16 = 2'b10,
                            WID_RSV = 2'b11} width_e;
  // Controller serial port sequencer states.
  typedef enum logic [1:0] {SPI_IDLE = 2'b00, SPI_LEAD = 2'b01, SPI_SHIFT = 2'b10,
                            SPI_TAIL = 2'b11} spi_state_e;
endpackage : audio_port_pkg

// ---- verilog/audio_port_if.sv ----
// Link between the converter serial port and the receiving controller.
`timescale 1ns/10ps
interface audio_port_if;
  logic bit_clk;     // Bit clock, driven by the converter.
  logic frame_clk;   // Frame clock, driven by the converter.
  logic serial_data; // Sample data, driven by the converter.
  logic spi_clk;     // Control port clock, driven by the controller.
  logic spi_sel_n;   // Control port select, active low.
  logic spi_data;    // Control port data toward the converter.
  // Converter end.
  modport dev (output bit_clk, output frame_clk, output serial_data,
               input spi_clk, input spi_sel_n, input spi_data);
  // Controller end.
  modport rx (input bit_clk, input frame_clk, input serial_data,
              output spi_clk, output spi_sel_n, output spi_data);
endinterface : audio_port_if

// ---- verilog/sync2.sv ----
// Two-stage synchroniser for a group of asynchronous levels.
`timescale 1ns/10ps
module sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_sys_in,
  input  wire logic             rst_in,
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] q_out
);
  // One pair of flip-flops per bit; the first stage feeds only the second.
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    logic meta_ff; // First stage, may be metastable.
    logic hold_ff; // Second stage, safe to use.
    // Each bit settles through two flip-flops before any logic sees it.
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
        meta_ff <= 1'b0;
        hold_ff <= 1'b0;
      end else begin
        meta_ff <= d_in[i];
        hold_ff <= meta_ff;
      end
    end
    assign q_out[i] = hold_ff;
  end
endmodule : sync2

// ---- verilog/adc_port_dev.sv ----
// Converter end: control word receiver and framed serial sample transmitter.
`timescale 1ns/10ps
`include "audio_port_regs.svh"
module adc_port_dev
  import audio_port_pkg::*;
(
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  audio_port_if.dev        link,
  input  wire logic [23:0] left_sample_in,
  input  wire logic [23:0] right_sample_in,
  input  wire logic        pin_mode_in,
  input  wire logic        rate_select_hi_in,
  input  wire logic        rate_select_lo_in,
  input  wire logic        format_select_hi_in,
  input  wire logic        format_select_lo_in,
  output logic             sample_take_out,
  output logic             highpass_enable_out,
  output logic [15:0]      control_word_out
);

  // Synchronised copies of the control port and the strap pins.
  logic [7:0] sy;
  logic       sy_sclk;     // Control port clock.
  logic       sy_sel_n;    // Control port select.
  logic       sy_mosi;     // Control port data.
  logic       sy_pin_mode; // Pins take over rate and format.
  logic [1:0] sy_rate_pin; // Rate pins.
  logic [1:0] sy_fmt_pin;  // Format pins.

  // Every asynchronous input passes two flip-flops first.
  sync2 #(
    .WIDTH (8)
  ) u_sync (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .d_in       ({link.spi_clk, link.spi_sel_n, link.spi_data, pin_mode_in,
                  rate_select_hi_in, rate_select_lo_in,
                  format_select_hi_in, format_select_lo_in}),
    .q_out      (sy)
  );

  assign sy_sclk     = sy[7];
  assign sy_sel_n    = sy[6];
  assign sy_mosi     = sy[5];
  assign sy_pin_mode = sy[4];
  assign sy_rate_pin = sy[3:2];
  assign sy_fmt_pin  = sy[1:0];

  // Control port receive state.
  logic        sclk_q_ff;  // Previous port clock, for edge detection.
  logic        sel_q_ff;   // Previous select, for the closing edge.
  logic [15:0] shift_ff;   // Incoming word, MSB first.
  logic [4:0]  cnt_ff;     // Bits taken in this selection.
  logic [15:0] ctrl_ff;    // Active control word.

  // Edge detection on the synchronised control port.
  wire sclk_rise = sy_sclk & ~sclk_q_ff;
  wire sel_rise  = sy_sel_n & ~sel_q_ff;
  wire word_full = (cnt_ff == `CW_COUNT);

  // Shift on each rising port clock while selected; extra bits are ignored.
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      sclk_q_ff <= 1'b0;
      sel_q_ff  <= 1'b1;
      shift_ff  <= `CW_RESET;
      cnt_ff    <= 5'h00;
    end else begin
      sclk_q_ff <= sy_sclk;
      sel_q_ff  <= sy_sel_n;
      if (sy_sel_n) begin
        cnt_ff <= 5'h00;
      end else if (sclk_rise && !word_full) begin
        shift_ff <= {shift_ff[14:0], sy_mosi};
        cnt_ff   <= cnt_ff + 5'h01;
      end
    end
  end

  // A word loads only when at least sixteen bits were taken, keeping the first sixteen,
  // so a torn transfer leaves the previous setting in force.
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_ff <= `CW_RESET;
    end else if (sel_rise && word_full) begin
      ctrl_ff <= shift_ff;
    end
  end

  // Field decode; reserved bits 15:10 reach only control_word_out.
  wire [1:0] word_rate = ctrl_ff[`CW_RATE_HI:`CW_RATE_LO];
  wire [1:0] word_fmt  = ctrl_ff[`CW_FMT_HI:`CW_FMT_LO];
  wire [1:0] word_wid  = ctrl_ff[`CW_WW_HI:`CW_WW_LO];
  wire       mute_l    = ctrl_ff[`CW_MUTE_L];
  wire       mute_r    = ctrl_ff[`CW_MUTE_R];

  // Pins override rate and format while pin mode is strapped high.
  wire [1:0] rate_sel = sy_pin_mode ? sy_rate_pin : word_rate;
  wire [1:0] fmt_sel  = sy_pin_mode ? sy_fmt_pin : word_fmt;
  wire       fmt_std  = (fmt_sel != FMT_LJ) && (fmt_sel != FMT_RJ);

  // Half period of the bit clock per rate; a reserved code falls back to 48 kHz.
  logic [3:0] half_cyc;
  always_comb begin
    case (rate_sel)
      RATE_96K:  half_cyc = 4'(`HALF_CYC(`FS_96K_HZ));
      RATE_192K: half_cyc = 4'(`HALF_CYC(`FS_192K_HZ));
      default:   half_cyc = 4'(`HALF_CYC(`FS_48K_HZ));
    endcase
  end

  // Sample width per code; the reserved code sends full 24-bit words.
  logic [5:0] wid;
  always_comb begin
    case (word_wid)
      WID_20:  wid = `BITS_20;
      WID_16:  wid = `BITS_16;
      default: wid = `BITS_24;
    endcase
  end

  // Bit clock generator and frame position.
  logic [3:0]  div_ff;    // System cycles into the current half period.
  logic        bclk_ff;   // Bit clock level.
  logic [5:0]  bit_ff;    // Bit period within the frame, 0 to 63.
  logic        lrclk_ff;  // Frame clock level.
  logic        sdata_ff;  // Serial data level.
  logic [23:0] left_hold_ff;
  logic [23:0] right_hold_ff;
  logic        take_ff;   // One-cycle pulse when a new pair is latched.

  // The divider is a true integer ratio of the system clock, so the bit clock
  // can only approach the nominal master-derived rate from below.
  wire half_end = (div_ff == half_cyc - 4'h1);
  wire fall     = half_end & bclk_ff;
  wire [5:0] nxt_bit = bit_ff + 6'h01;
  wire [4:0] pos     = nxt_bit[4:0];
  wire       slot    = nxt_bit[5];               // Slot 0 is left, 1 right.
  wire       latch   = fall && (nxt_bit == `FRAME_LAST);

  // Leading blank periods before the MSB, per format.
  wire [5:0] skip = (fmt_sel == FMT_RJ) ? (`SLOT_SIZE - wid) :
                    (fmt_sel == FMT_LJ) ? 6'h00 : 6'h01;
  wire [5:0] pos6    = {1'b0, pos};
  wire [5:0] ordinal = pos6 - skip;              // Bit number counted from the MSB.
  wire       in_word = (pos6 >= skip) && (ordinal < wid);
  wire [23:0] word   = slot ? right_hold_ff : left_hold_ff;
  wire [4:0]  idx    = 5'(`SAMPLE_MSB - ordinal);
  // Periods outside the word go low.
  wire nxt_sdata     = in_word & word[idx];
  // Standard mode holds the frame clock low for left, the justified modes high.
  wire nxt_lrclk     = fmt_std ? slot : ~slot;

  // Divider and bit clock toggle.
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      div_ff  <= 4'h0;
      bclk_ff <= 1'b1;
    end else if (half_end) begin
      div_ff  <= 4'h0;
      bclk_ff <= ~bclk_ff;
    end else begin
      div_ff  <= div_ff + 4'h1;
    end
  end

  // Frame clock and data move together on each falling bit clock edge, so
  // the receiver samples stable data on the following rising edge.
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      bit_ff   <= `FRAME_LAST;
      lrclk_ff <= 1'b1;
      sdata_ff <= 1'b0;
    end else if (fall) begin
      bit_ff   <= nxt_bit;
      lrclk_ff <= nxt_lrclk;
      sdata_ff <= nxt_sdata;
    end
  end

  // Samples are latched while the last right period is being set up; that
  // period still reads the old hold because the update lands afterwards.
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      left_hold_ff  <= 24'h000000;
      right_hold_ff <= 24'h000000;
      take_ff       <= 1'b0;
    end else begin
      take_ff <= latch;
      if (latch) begin
        left_hold_ff  <= mute_l ? 24'h000000 : left_sample_in;
        right_hold_ff <= mute_r ? 24'h000000 : right_sample_in;
      end
    end
  end

  // Only the three framing signals leave toward the receiver.
  assign link.bit_clk      = bclk_ff;
  assign link.frame_clk    = lrclk_ff;
  assign link.serial_data  = sdata_ff;
  assign sample_take_out     = take_ff;
  assign highpass_enable_out = ctrl_ff[`CW_HPE];
  assign control_word_out    = ctrl_ff;

endmodule : adc_port_dev

// ---- verilog/ctrl_port_rx.sv ----
// Controller end: sends the control word and captures framed samples.
`timescale 1ns/10ps
`include "audio_port_regs.svh"
module ctrl_port_rx
  import audio_port_pkg::*;
(
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  audio_port_if.rx         link,
  input  wire logic [7:0]  addr_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic [31:0]      rdata_out,
  output logic             frame_out
);

  // Synchronised link inputs: bit clock, frame clock, data.
  logic [2:0] sy;
  sync2 #(
    .WIDTH (3)
  ) u_sync (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .d_in       ({link.bit_clk, link.frame_clk, link.serial_data}),
    .q_out      (sy)
  );

  logic        bclk_q_ff;   // Previous bit clock.
  logic        lr_q_ff;     // Frame clock at the previous rising edge.
  logic [4:0]  pos_ff;      // Slot position of the last bit taken.
  logic [31:0] sh_ff;       // Slot bits, first bit oldest.
  logic [23:0] left_ff;     // Last left sample, MSB aligned.
  logic [23:0] right_ff;    // Last right sample, MSB aligned.
  logic        ready_ff;    // Sticky: a right sample has arrived.
  logic        frame_ff;    // One-cycle pulse per completed right sample.
  logic [15:0] ctrl_ff;     // Word last sent; also tells framing.
  logic [31:0] rdata_ff;    // Read data, valid the cycle after the strobe.

  // Data changes on the falling edge, so it is taken on the rising edge.
  wire bit_rise = sy[2] & ~bclk_q_ff;
  // A frame clock change starts a new slot at position zero.
  wire [4:0] cur_pos = (sy[1] != lr_q_ff) ? 5'h00 : pos_ff + 5'h01;
  wire [31:0] nxt_sh = {sh_ff[30:0], sy[0]};
  wire [1:0]  fmt    = ctrl_ff[`CW_FMT_HI:`CW_FMT_LO];
  wire        std    = (fmt != FMT_LJ) && (fmt != FMT_RJ);
  wire        is_left = std ? ~sy[1] : sy[1];
  wire        slot_end = bit_rise && (cur_pos == `SLOT_LAST);

  // Width and alignment of the sample inside the slot.
  wire [1:0] wcode = ctrl_ff[`CW_WW_HI:`CW_WW_LO];
  wire [5:0] wid = (wcode == WID_20) ? `BITS_20 :
                   (wcode == WID_16) ? `BITS_16 : `BITS_24;
  wire [5:0] lshift = (fmt == FMT_RJ) ? (`SLOT_SIZE - wid) :
                      (fmt == FMT_LJ) ? 6'h00 : 6'h01;
  wire [31:0] aligned = nxt_sh << lshift;
  wire [23:0] mask    = 24'hffffff << (`BITS_24 - wid);
  // Bits after the word are dropped, so trailing padding never leaks in.
  wire [23:0] sample  = aligned[31:8] & mask;

  // Slot tracking and sample capture.
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      bclk_q_ff <= 1'b0;
      lr_q_ff   <= 1'b0;
      pos_ff    <= 5'h00;
      sh_ff     <= 32'h00000000;
      left_ff   <= 24'h000000;
      right_ff  <= 24'h000000;
    end else begin
      bclk_q_ff <= sy[2];
      if (bit_rise) begin
        lr_q_ff <= sy[1];
        pos_ff  <= cur_pos;
        sh_ff   <= nxt_sh;
      end
      if (slot_end && is_left) begin
        left_ff <= sample;
      end
      if (slot_end && !is_left) begin
        right_ff <= sample;
      end
    end
  end

  // Register decode.
  wire wr_ctrl  = wr_in && (addr_in == `REG_CTRL);
  wire rd_stat  = rd_in && (addr_in == `REG_STATUS);
  wire set_rdy  = slot_end && !is_left;
  spi_state_e state_ff;
  wire busy = (state_ff != SPI_IDLE);

  // Ready is set by a finished pair and cleared by a status read; a set in
  // the same cycle as the clear wins, so no frame is lost.
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      ready_ff <= 1'b0;
      frame_ff <= 1'b0;
    end else begin
      ready_ff <= set_rdy | (ready_ff & ~rd_stat);
      frame_ff <= set_rdy;
    end
  end

  // Read mux; unmapped addresses read zero.
  wire [31:0] rd_mux =
    (addr_in == `REG_CTRL)   ? {16'h0000, ctrl_ff} :
    (addr_in == `REG_STATUS) ? {30'h00000000, ready_ff, busy} :
    (addr_in == `REG_LEFT)   ? {8'h00, left_ff} :
    (addr_in == `REG_RIGHT)  ? {8'h00, right_ff} : 32'h00000000;

  // Read data stands only in the cycle after the strobe.
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_ff <= 32'h00000000;
    end else begin
      rdata_ff <= rd_in ? rd_mux : 32'h00000000;
    end
  end

  // Serial control port master.
  logic [3:0]  tm_ff;   // Half period timer.
  logic [3:0]  n_ff;    // Bits already sent.
  logic [15:0] tx_ff;   // Word being sent, MSB first.
  logic        sclk_ff;
  logic        sel_n_ff;
  wire tick = (tm_ff == `SPI_HALF_CYC - 4'h1);

  // A write to the control register while busy is ignored, which keeps a
  // half-sent word from being torn; software polls the busy bit.
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      state_ff <= SPI_IDLE;
      tm_ff    <= 4'h0;
      n_ff     <= 4'h0;
      tx_ff    <= `CW_RESET;
      ctrl_ff  <= `CW_RESET;
      sclk_ff  <= 1'b0;
      sel_n_ff <= 1'b1;
    end else begin
      tm_ff <= (tick || !busy) ? 4'h0 : tm_ff + 4'h1;
      case (state_ff)
        SPI_IDLE: begin
          if (wr_ctrl) begin
            ctrl_ff  <= wdata_in[15:0];
            tx_ff    <= wdata_in[15:0];
            n_ff     <= 4'h0;
            sel_n_ff <= 1'b0;
            state_ff <= SPI_LEAD;
          end
        end
        SPI_LEAD: begin
          if (tick) begin
            sclk_ff  <= 1'b1;
            state_ff <= SPI_SHIFT;
          end
        end
        SPI_SHIFT: begin
          if (tick && sclk_ff) begin
            sclk_ff <= 1'b0;
            tx_ff   <= {tx_ff[14:0], 1'b0};
            n_ff    <= n_ff + 4'h1;
            if (n_ff == 4'hf) begin
              state_ff <= SPI_TAIL;
            end
          end else if (tick) begin
            sclk_ff <= 1'b1;
          end
        end
        SPI_TAIL: begin
          if (tick && !sel_n_ff) begin
            sel_n_ff <= 1'b1;
          end else if (tick) begin
            state_ff <= SPI_IDLE;
          end
        end
        default: begin
          state_ff <= SPI_IDLE;
        end
      endcase
    end
  end

  assign link.spi_clk   = sclk_ff;
  assign link.spi_sel_n = sel_n_ff;
  assign link.spi_data  = tx_ff[15];
  assign rdata_out = rdata_ff;
  assign frame_out = frame_ff;

endmodule : ctrl_port_rx

// ---- tb/audio_port_assertions.sv ----
// Concurrent checks on the audio link and the control port wires.
`timescale 1ns/10ps
module audio_port_assertions (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic bit_clk,
  input wire logic frame_clk,
  input wire logic serial_data,
  input wire logic spi_clk,
  input wire logic spi_sel_n,
  input wire logic spi_data
);
  logic       fc_ff, bc_ff, sc_ff; // Last sampled clock levels.
  logic [1:0] settle_ff;           // Frame moves since the last control word.
  logic [3:0] half_ff;             // Cycles the bit clock held its level.
  logic [5:0] fall_ff;             // Bit clock falls in the current slot.
  logic [4:0] rise_ff;             // Control clock rises in the current word.
  wire        fc_chg  = frame_clk != fc_ff;
  wire        bc_fall = !bit_clk && bc_ff;
  wire        settled = settle_ff == 2'h3;
  // A new word may reshape the link at once, so link checks wait three frame moves.
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      {fc_ff, bc_ff, sc_ff} <= 3'h6;
      {settle_ff, half_ff, fall_ff, rise_ff} <= 17'h0;
    end else begin
      {fc_ff, bc_ff, sc_ff} <= {frame_clk, bit_clk, spi_clk};
      settle_ff <= !spi_sel_n ? 2'h0 : (fc_chg && !settled) ? settle_ff + 2'h1 : settle_ff;
      half_ff <= (bit_clk != bc_ff) ? 4'h1 : (half_ff == 4'hf) ? half_ff : half_ff + 4'h1;
      fall_ff <= fc_chg ? 6'h1 : (bc_fall && fall_ff != 6'h3f) ? fall_ff + 6'h1 : fall_ff;
      rise_ff <= spi_sel_n ? 5'h0 : (spi_clk && !sc_ff) ? rise_ff + 5'h1 : rise_ff;
    end
  end
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  property p_frame_edge; settled && $changed(frame_clk) |-> $fell(bit_clk); endproperty
  property p_slot_len; settled && $changed(frame_clk) |-> fall_ff == 6'h20; endproperty
  property p_bit_half; settled && $changed(bit_clk) |-> half_ff inside {4'h2, 4'h4, 4'h7};
  endproperty
  property p_data_edge; settled && $changed(serial_data) |-> $fell(bit_clk); endproperty
  property p_spi_idle; spi_sel_n |-> !spi_clk; endproperty
  property p_spi_hold; $rose(spi_clk) |=> $stable(spi_data) [*3]; endproperty
  property p_spi_count; $rose(spi_sel_n) |-> rise_ff == 5'h10; endproperty
  property p_spi_len; $fell(spi_sel_n) |-> ##[130:140] $rose(spi_sel_n); endproperty
  a_frame_edge: assert property (p_frame_edge) else $error("frame clock off a fall");
  a_slot_len: assert property (p_slot_len) else $error("slot not 32 bits");
  a_bit_half: assert property (p_bit_half) else $error("bad bit clock half");
  a_data_edge: assert property (p_data_edge) else $error("data off a fall");
  a_spi_idle: assert property (p_spi_idle) else $error("control clock idle");
  a_spi_hold: assert property (p_spi_hold) else $error("control data moved");
  a_spi_count: assert property (p_spi_count) else $error("word not 16 bits");
  a_spi_len: assert property (p_spi_len) else $error("word length off");
  c_word: cover property ($rose(spi_sel_n));
  c_frame: cover property (settled && $rose(frame_clk));
  c_data: cover property (settled && $rose(serial_data));
endmodule : audio_port_assertions

// ---- tb/audio_adc_serial_output_port_tb_top.sv ----
// Bench joining the converter end and the controller end over the link.
`timescale 1ns/10ps
`include "audio_port_regs.svh"
module audio_adc_serial_output_port_tb_top
  import audio_port_pkg::*;
;
  logic        clk_sys_in, rst_in, pin_mode, wr, rd;
  logic [23:0] left_smp, right_smp; // Samples into the converter.
  logic [3:0]  cfg_pins;            // Format pins high pair, rate pins low pair.
  logic [7:0]  addr;
  logic [31:0] wdata;
  wire  [31:0] rdata;
  wire         frame, highpass_enable;
  wire         take;                // Converter latch pulse, one per frame.
  wire  [15:0] cw;                  // Word the converter holds.
  int          num_errors, n_compared, seed, n_take;
  audio_port_if link();
  adc_port_dev i_adc_port_dev (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .link(link),
    .left_sample_in(left_smp), .right_sample_in(right_smp), .pin_mode_in(pin_mode),
    .rate_select_hi_in(cfg_pins[1]), .rate_select_lo_in(cfg_pins[0]),
    .format_select_hi_in(cfg_pins[3]), .format_select_lo_in(cfg_pins[2]),
    .sample_take_out(take), .highpass_enable_out(highpass_enable), .control_word_out(cw));
  // Counts converter latch pulses; exactly one pair is taken per frame.
  always @(posedge clk_sys_in) n_take <= rst_in ? 0 : n_take + ((take === 1'b1) ? 1 : 0);
  ctrl_port_rx i_ctrl_port_rx (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .link(link),
    .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
    .frame_out(frame));
  audio_port_assertions i_audio_port_assertions (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .bit_clk(link.bit_clk), .frame_clk(link.frame_clk), .serial_data(link.serial_data),
    .spi_clk(link.spi_clk), .spi_sel_n(link.spi_sel_n), .spi_data(link.spi_data));
  // Free-running 40 MHz system clock.
  initial begin
    clk_sys_in = 1'b0;
    forever #12.5 clk_sys_in = ~clk_sys_in;
  end
  task automatic final_report;
    $display("Compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // A wait that runs out is a mismatch and ends the run.
  task automatic hang;
    chk(32'h0, 32'h1);
    final_report;
  endtask : hang
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys_in);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys_in);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg
  task automatic wait_frame;
    int k;
    for (k = 0; k < 4000; k++) begin
      @(posedge clk_sys_in);
      #1 if (frame === 1'b1) break;
    end
    if (k == 4000) hang;
  endtask : wait_frame
  // Takes the first two bits of the slot that starts when the frame clock reaches lvl.
  task automatic grab(input logic lvl, output logic [1:0] b);
    int k, n;
    logic pf, pb;
    n = 0;
    pf = link.frame_clk;
    pb = link.bit_clk;
    for (k = 0; k < 4000 && n < 3; k++) begin
      @(posedge clk_sys_in);
      #1 if (n == 0 && link.frame_clk === lvl && pf !== lvl) n = 1;
      else if (n > 0 && link.bit_clk === 1'b1 && pb === 1'b0) begin
        b[2-n] = link.serial_data;
        n++;
      end
      pf = link.frame_clk;
      pb = link.bit_clk;
    end
    if (n < 3) hang;
  endtask : grab
  // Captured sample: upper width bits kept, zero when muted.
  function automatic logic [31:0] exp_smp(input logic [23:0] s, input logic [1:0] wid,
                                          input logic mute);
    logic [23:0] m;
    m = (wid == WID_20) ? 24'hfffff0 : (wid == WID_16) ? 24'hffff00 : 24'hffffff;
    return mute ? 32'h0 : {8'h00, s & m};
  endfunction : exp_smp
  // Each pass sets a format, rate and width, then checks register and wire views.
  initial begin : main
    logic [31:0] d, w;
    logic [1:0]  b, e;
    logic        ml, m22;
    int          i, k, t;
    {seed, num_errors, n_compared} = {32'd24, 64'd0};
    {rst_in, pin_mode, wr, rd, cfg_pins, addr, wdata} = {1'b1, 47'h0};
    {left_smp, right_smp} = 48'h0;
    repeat (5) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    #1 chk({16'h0, cw}, 32'h0);
    rd_reg(8'h10, d);
    chk(d, 32'h0);
    wr_reg(8'h10, 32'hffff);
    rd_reg(`REG_CTRL, d);
    chk(d, 32'h0);
    for (i = 0; i < 16; i++) begin
      w = $random(seed);
      w[4:3] = i[1:0];
      w[2:1] = i[2:1];
      w[9:8] = i[3:2];
      @(posedge clk_sys_in);
      left_smp <= 24'($random(seed));
      right_smp <= 24'($random(seed));
      pin_mode <= w[30];
      // Pins match the word while in force; otherwise they are random and must be ignored.
      cfg_pins <= w[30] ? w[4:1] : w[28:25];
      wr_reg(`REG_CTRL, {16'h0, w[15:0]});
      wr_reg(`REG_CTRL, {16'h0, ~w[15:0]});
      for (k = 0; k < 200; k++) begin
        rd_reg(`REG_STATUS, d);
        if (d[`ST_BUSY] === 1'b0) break;
      end
      if (k == 200) hang;
      rd_reg(`REG_CTRL, d);
      chk(d, {16'h0, w[15:0]});
      wait_frame;
      t = n_take;
      repeat (2) wait_frame;
      chk(n_take - t, 2);
      chk({16'h0, cw}, {16'h0, w[15:0]});
      chk({31'h0, highpass_enable}, {31'h0, w[0]});
      rd_reg(`REG_LEFT, d);
      chk(d, exp_smp(left_smp, w[9:8], w[6]));
      rd_reg(`REG_RIGHT, d);
      chk(d, exp_smp(right_smp, w[9:8], w[7]));
      ml = left_smp[23] & ~w[6];
      m22 = left_smp[22] & ~w[6];
      e = (w[4:3] == FMT_LJ) ? {ml, m22} : (w[4:3] == FMT_RJ) ? 2'b00 : {1'b0, ml};
      grab(w[4:3] == FMT_LJ || w[4:3] == FMT_RJ, b);
      chk({30'h0, b}, {30'h0, e});
    end
    final_report;
  end
endmodule : audio_adc_serial_output_port_tb_top
